//--- cap_scan_pkg.sv
package cap_scan_pkg;
  // APB register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h0C;
  localparam logic [7:0] SCALE_OFF = 8'h10;
  localparam logic [7:0] OFFSET_OFF = 8'h14;
  localparam logic [7:0] THRESH_OFF = 8'h18;
  localparam logic [7:0] IDLE_OFF = 8'h1C;
  localparam logic [7:0] TOUCH_OFF = 8'h20;
  localparam logic [7:0] DATA_OFF = 8'h40;
  // CTRL fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SRST_BIT = 1;
  // IRQ bit positions
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_SCAN_BIT = 1;
  localparam int IRQ_TOUCH_BIT = 2;
  // Reset values
  localparam logic [7:0] SCALE_RST = 8'h10;
  localparam logic [9:0] OFFSET_RST = 10'h000;
  localparam logic [9:0] THRESH_RST = 10'h040;
  localparam logic [15:0] IDLE_RST = 16'h0010;
  // Slave address choices
  localparam logic [6:0] ADDR_LO = 7'h5A;
  localparam logic [6:0] ADDR_HI = 7'h5B;
  // Settle count in clk_sys cycles, debounce count in scans, calibration shift
  localparam int SETTLE_CYC = 4;
  localparam int DEBOUNCE_CNT = 3;
  localparam int CAL_SHIFT = 4;
  typedef enum {ST_OFF, ST_SELECT, ST_SETTLE, ST_CONV, ST_WAIT, ST_STORE,
                ST_SLEEP} seq_e;
endpackage

//--- cap_sensor_scan_power_seq.sv
`timescale 1ns/1ps
// Function
// - Scan all sixteen sensor channels in sequence each scan.
// - Each sample is an unsigned 10-bit code, full scale equals supply.
// - Sequencer drives front-end strobes and selects converted channel.
// - Results are scaled, offset and saturated before storage; touch state is debounced.
// - Per-channel baseline recalibrates against slow drift while the channel is untouched.
// - Corrected results stored in host-readable data registers.
// - Enter low-power mode by itself when no sensor is touched.
// - Low-power mode rescans after one idle period; a touch then keeps device scanning.
// - Touch wake-up drives the interrupt output.
// - Soft-reset command or shutdown pin return device to initial state.
// - Shutdown pin low halts all operation; high allows operation.
// - Address-select low gives address 5Ah, high gives 5Bh.
module cap_sensor_scan_power_seq #(
  parameter int CHANNELS = 16,
  parameter int DEBOUNCE = cap_scan_pkg::DEBOUNCE_CNT
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Pins
  input wire logic shutdown_pin_i,
  input wire logic addr_sel_i,
  output logic [6:0] slave_addr_o,
  output logic irq_o,
  // Analogue front end and converter
  output logic [3:0] chan_sel_o,
  output logic afe_precharge_o,
  output logic adc_start_o,
  output logic low_power_o,
  input wire logic adc_done_i,
  input wire logic [9:0] adc_data_i,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  if (CHANNELS != 16 || DEBOUNCE < 1 || DEBOUNCE > 7) begin : g_bad_param
    $error("unsupported parameters");
  end

  // Pin synchronisers
  logic [1:0] sdn_sync_reg, sdn_sync_next;
  logic [1:0] as_sync_reg, as_sync_next;
  logic [1:0] done_sync_reg, done_sync_next;
  logic run, as_lvl;
  always_comb begin
    sdn_sync_next = {sdn_sync_reg[0], shutdown_pin_i};
    as_sync_next = {as_sync_reg[0], addr_sel_i};
    done_sync_next = {done_sync_reg[0], adc_done_i};
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sdn_sync_reg <= 2'h0;
      as_sync_reg <= 2'h0;
      done_sync_reg <= 2'h0;
    end else begin
      sdn_sync_reg <= sdn_sync_next;
      as_sync_reg <= as_sync_next;
      done_sync_reg <= done_sync_next;
    end
  end
  assign as_lvl = as_sync_reg[1];

  // Registers
  logic en_reg, en_next;
  logic srst;
  logic [2:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [7:0] scale_reg, scale_next;
  logic [9:0] offset_reg, offset_next, thresh_reg, thresh_next;
  logic [15:0] idle_reg, idle_next;
  logic [6:0] addr_reg, addr_next;
  logic [31:0] prdata_reg, prdata_next;
  // Per-channel state
  logic [9:0] data_mem [16];
  logic [13:0] base_mem [16];
  logic [2:0] deb_mem [16];
  logic [15:0] touch_reg, touch_next;
  logic ch_we;
  logic [9:0] ch_data;
  logic [13:0] ch_base;
  logic [2:0] ch_deb;

  cap_scan_pkg::seq_e st_reg, st_next;
  logic [3:0] ch_reg, ch_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] idle_cnt_reg, idle_cnt_next;
  logic [9:0] raw_reg, raw_next;
  logic [2:0] ev;
  logic wr, rd;
  // Halt while shutdown low or soft reset requested
  logic hold;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign srst = wr && paddr == cap_scan_pkg::CTRL_OFF &&
                pwdata[cap_scan_pkg::CTRL_SRST_BIT];
  assign run = sdn_sync_reg[1];
  assign hold = !run || srst;

  function automatic logic [9:0] sat10(input logic [19:0] v);
    sat10 = (v > 20'h003FF) ? 10'h3FF : v[9:0];
  endfunction

  // Correction: scale (x/16), add offset, saturate to 10 bits
  logic [17:0] scaled;
  logic [9:0] corr;
  logic [9:0] base10;
  logic above;
  always_comb begin
    scaled = {8'h00, raw_reg} * {10'h000, scale_reg};
    corr = sat10({6'h00, scaled[17:4]} + {10'h000, offset_reg});
    base10 = base_mem[ch_reg][13:4];
    above = (corr > base10) && ((corr - base10) > thresh_reg);
  end

  // Sequencer
  always_comb begin
    st_next = st_reg;
    ch_next = ch_reg;
    cnt_next = cnt_reg;
    raw_next = raw_reg;
    idle_cnt_next = idle_cnt_reg;
    touch_next = touch_reg;
    ev = 3'h0;
    ch_we = 1'b0;
    ch_data = data_mem[ch_reg];
    ch_base = base_mem[ch_reg];
    ch_deb = deb_mem[ch_reg];
    case (st_reg)
      cap_scan_pkg::ST_OFF: begin
        if (en_reg) begin
          st_next = cap_scan_pkg::ST_SELECT;
          ch_next = 4'h0;
        end
      end
      cap_scan_pkg::ST_SELECT: begin
        cnt_next = 16'h0000;
        st_next = cap_scan_pkg::ST_SETTLE;
      end
      cap_scan_pkg::ST_SETTLE: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(cap_scan_pkg::SETTLE_CYC - 1))
          st_next = cap_scan_pkg::ST_CONV;
      end
      cap_scan_pkg::ST_CONV: st_next = cap_scan_pkg::ST_WAIT;
      cap_scan_pkg::ST_WAIT: begin
        if (done_sync_reg[1]) begin
          raw_next = adc_data_i;
          st_next = cap_scan_pkg::ST_STORE;
        end
      end
      cap_scan_pkg::ST_STORE: begin
        ch_we = 1'b1;
        ch_data = corr;
        if (above == touch_reg[ch_reg]) begin
          ch_deb = 3'h0;
          // Track drift only while untouched
          if (!touch_reg[ch_reg])
            ch_base = base_mem[ch_reg] - {4'h0, base10} +
                      {4'h0, corr};
        end else if (ch_deb == 3'(DEBOUNCE - 1)) begin
          ch_deb = 3'h0;
          touch_next[ch_reg] = above;
          ev[cap_scan_pkg::IRQ_TOUCH_BIT] = 1'b1;
        end else begin
          ch_deb = ch_deb + 3'h1;
        end
        ch_next = ch_reg + 4'h1;
        st_next = cap_scan_pkg::ST_SELECT;
        if (ch_reg == 4'hF) begin
          ev[cap_scan_pkg::IRQ_SCAN_BIT] = 1'b1;
          if (touch_next != 16'h0000) begin
            idle_cnt_next = 16'h0000;
          end else if (idle_cnt_reg >= idle_reg) begin
            st_next = cap_scan_pkg::ST_SLEEP;
            cnt_next = 16'h0000;
          end else begin
            idle_cnt_next = idle_cnt_reg + 16'h0001;
          end
        end
        if (!en_reg)
          st_next = cap_scan_pkg::ST_OFF;
      end
      cap_scan_pkg::ST_SLEEP: begin
        // Wait one idle period, then rescan from channel 0
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg >= idle_reg) begin
          idle_cnt_next = 16'h0000;
          st_next = cap_scan_pkg::ST_SELECT;
          ch_next = 4'h0;
        end
      end
      default: st_next = cap_scan_pkg::ST_OFF;
    endcase
  end

  // Wake: a touch seen during the first scan after sleep
  logic woke_reg, woke_next;
  always_comb begin
    woke_next = woke_reg;
    if (st_reg == cap_scan_pkg::ST_SLEEP)
      woke_next = 1'b1;
    else if (st_reg == cap_scan_pkg::ST_STORE && ch_reg == 4'hF)
      woke_next = 1'b0;
    if (woke_reg && st_reg == cap_scan_pkg::ST_STORE && above)
      woke_next = 1'b0;
  end
  logic wake_ev;
  assign wake_ev = woke_reg && st_reg == cap_scan_pkg::ST_STORE &&
                   above;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || hold) begin
      st_reg <= cap_scan_pkg::ST_OFF;
      ch_reg <= 4'h0;
      cnt_reg <= 16'h0000;
      raw_reg <= 10'h000;
      idle_cnt_reg <= 16'h0000;
      touch_reg <= 16'h0000;
      woke_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ch_reg <= ch_next;
      cnt_reg <= cnt_next;
      raw_reg <= raw_next;
      idle_cnt_reg <= idle_cnt_next;
      touch_reg <= touch_next;
      woke_reg <= woke_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || hold) begin
      for (int i = 0; i < 16; i++) begin
        data_mem[i] <= 10'h000;
        base_mem[i] <= 14'h0000;
        deb_mem[i] <= 3'h0;
      end
    end else if (ch_we) begin
      data_mem[ch_reg] <= ch_data;
      base_mem[ch_reg] <= ch_base;
      deb_mem[ch_reg] <= ch_deb;
    end
  end

  // Register file and interrupts
  always_comb begin
    en_next = en_reg;
    scale_next = scale_reg;
    offset_next = offset_reg;
    thresh_next = thresh_reg;
    idle_next = idle_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    addr_next = as_lvl ? cap_scan_pkg::ADDR_HI
                       : cap_scan_pkg::ADDR_LO;
    if (wr) begin
      case (paddr)
        cap_scan_pkg::CTRL_OFF: en_next = pwdata[cap_scan_pkg::CTRL_EN_BIT];
        cap_scan_pkg::SCALE_OFF: scale_next = pwdata[7:0];
        cap_scan_pkg::OFFSET_OFF: offset_next = pwdata[9:0];
        cap_scan_pkg::THRESH_OFF: thresh_next = pwdata[9:0];
        cap_scan_pkg::IDLE_OFF: idle_next = pwdata[15:0];
        cap_scan_pkg::IRQ_MASK_OFF: irq_mask_next = pwdata[2:0];
        cap_scan_pkg::IRQ_STAT_OFF: irq_stat_next = irq_stat_reg & ~pwdata[2:0];
        default: ;
      endcase
    end
    // Set wins over clear
    irq_stat_next = irq_stat_next | ev;
    if (wake_ev)
      irq_stat_next[cap_scan_pkg::IRQ_WAKE_BIT] = 1'b1;
    prdata_next = prdata_reg;
    if (rd) begin
      prdata_next = 32'h00000000;
      if (paddr >= cap_scan_pkg::DATA_OFF && paddr[1:0] == 2'h0 &&
          paddr < 8'(cap_scan_pkg::DATA_OFF + 8'h40))
        prdata_next = {22'h0, data_mem[paddr[5:2]]};
      else begin
        case (paddr)
          cap_scan_pkg::CTRL_OFF: prdata_next = {31'h0, en_reg};
          cap_scan_pkg::STATUS_OFF:
            prdata_next = {20'h0, 1'b0, addr_reg, low_power_o, 3'h0};
          cap_scan_pkg::IRQ_STAT_OFF: prdata_next = {29'h0, irq_stat_reg};
          cap_scan_pkg::IRQ_MASK_OFF: prdata_next = {29'h0, irq_mask_reg};
          cap_scan_pkg::SCALE_OFF: prdata_next = {24'h0, scale_reg};
          cap_scan_pkg::OFFSET_OFF: prdata_next = {22'h0, offset_reg};
          cap_scan_pkg::THRESH_OFF: prdata_next = {22'h0, thresh_reg};
          cap_scan_pkg::IDLE_OFF: prdata_next = {16'h0, idle_reg};
          cap_scan_pkg::TOUCH_OFF: prdata_next = {16'h0, touch_reg};
          default: prdata_next = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || hold) begin
      en_reg <= 1'b0;
      scale_reg <= cap_scan_pkg::SCALE_RST;
      offset_reg <= cap_scan_pkg::OFFSET_RST;
      thresh_reg <= cap_scan_pkg::THRESH_RST;
      idle_reg <= cap_scan_pkg::IDLE_RST;
      irq_mask_reg <= 3'h0;
      irq_stat_reg <= 3'h0;
      // Address follows its pin through soft reset and shutdown
      addr_reg <= rst_i ? cap_scan_pkg::ADDR_LO : addr_next;
      prdata_reg <= 32'h00000000;
    end else begin
      en_reg <= en_next;
      scale_reg <= scale_next;
      offset_reg <= offset_next;
      thresh_reg <= thresh_next;
      idle_reg <= idle_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
      addr_reg <= addr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);
  assign slave_addr_o = addr_reg;
  assign chan_sel_o = ch_reg;
  assign afe_precharge_o = st_reg == cap_scan_pkg::ST_SETTLE;
  assign adc_start_o = st_reg == cap_scan_pkg::ST_CONV;
  assign low_power_o = st_reg == cap_scan_pkg::ST_SLEEP ||
                       st_reg == cap_scan_pkg::ST_OFF;
endmodule // cap_sensor_scan_power_seq

//--- cap_scan_properties.sv
`timescale 1ns/1ps
module cap_scan_checker #(
  parameter int CHANNELS = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Pins
  input wire logic shutdown_pin_i,
  input wire logic addr_sel_i,
  input wire logic [6:0] slave_addr_o,
  input wire logic irq_o,
  // Front end
  input wire logic [3:0] chan_sel_o,
  input wire logic afe_precharge_o,
  input wire logic adc_start_o,
  input wire logic low_power_o,
  // APB
  input wire logic psel,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  start_pulse_a: assert property (
    adc_start_o |=> !adc_start_o) else $error("start too wide");
  start_settled_a: assert property (
    adc_start_o |-> $past(afe_precharge_o) && !afe_precharge_o)
    else $error("start without settle");
  settle_len_a: assert property (
    disable iff (rst_i || !shutdown_pin_i || low_power_o)
    $rose(afe_precharge_o) |-> afe_precharge_o[*4] ##1 !afe_precharge_o)
    else $error("settle length wrong");
  chan_step_a: assert property (
    $changed(chan_sel_o) && chan_sel_o != 4'h0 |->
    chan_sel_o == $past(chan_sel_o) + 4'h1 && 32'(chan_sel_o) < CHANNELS)
    else $error("channel skipped");
  addr_pick_a: assert property (
    disable iff (rst_i || !shutdown_pin_i)
    $stable(addr_sel_i)[*8] |-> slave_addr_o == (addr_sel_i ? 7'h5B : 7'h5A))
    else $error("slave address wrong");
  sleep_quiet_a: assert property (
    low_power_o |-> !adc_start_o && !afe_precharge_o)
    else $error("activity in low power");
  halt_all_a: assert property (
    !shutdown_pin_i[*4] |->
    low_power_o && !irq_o && !adc_start_o && chan_sel_o == 4'h0)
    else $error("running while shut down");
  apb_ready_a: assert property (
    psel |-> pready && !pslverr) else $error("bus answer wrong");
endmodule // cap_scan_checker
bind cap_sensor_scan_power_seq cap_scan_checker #(.CHANNELS(CHANNELS)) chk_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .shutdown_pin_i(shutdown_pin_i),
  .addr_sel_i(addr_sel_i), .slave_addr_o(slave_addr_o), .irq_o(irq_o),
  .chan_sel_o(chan_sel_o), .afe_precharge_o(afe_precharge_o),
  .adc_start_o(adc_start_o), .low_power_o(low_power_o), .psel(psel),
  .pready(pready), .pslverr(pslverr));

//--- adc_partner.sv
`timescale 1ns/1ps
module adc_partner (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Converter side
  input wire logic start_i,
  input wire logic [9:0] code_i,
  input wire logic [3:0] lag_i,
  output logic done_o,
  output logic [9:0] data_o
);
  int cnt;
  int hold;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt <= 0;
      hold <= 0;
      done_o <= 1'b0;
      data_o <= 10'h155;
    end else if (start_i) begin
      cnt <= 32'(lag_i) + 1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      hold <= 4;
      done_o <= 1'b1;
      data_o <= code_i;
    end else if (hold > 1) begin
      hold <= hold - 1;
    end else if (done_o) begin
      // Released result no longer shows the last code
      done_o <= 1'b0;
      data_o <= ~data_o;
    end
  end
endmodule // adc_partner

//--- tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys_i, rst_i, shutdown_pin_i, addr_sel_i, irq_o, adc_done_i;
  logic afe_precharge_o, adc_start_o, low_power_o, psel, penable, pwrite;
  logic pready, pslverr;
  logic [6:0] slave_addr_o;
  logic [3:0] chan_sel_o, lag;
  logic [9:0] adc_data_i, code;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lf;
  int error_cnt, total_checks;
  int exp_q[$];
  cap_sensor_scan_power_seq #(.CHANNELS(16), .DEBOUNCE(3))
    cap_sensor_scan_power_seq_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .shutdown_pin_i(shutdown_pin_i), .addr_sel_i(addr_sel_i),
    .slave_addr_o(slave_addr_o), .irq_o(irq_o), .chan_sel_o(chan_sel_o),
    .afe_precharge_o(afe_precharge_o), .adc_start_o(adc_start_o),
    .low_power_o(low_power_o), .adc_done_i(adc_done_i),
    .adc_data_i(adc_data_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  adc_partner adc_partner_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .start_i(adc_start_o), .code_i(code), .lag_i(lag),
    .done_o(adc_done_i), .data_o(adc_data_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int corr(int raw, int s, int o);
    int v;
    v = raw * s / 16 + o;
    return (v > 1023) ? 1023 : v;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) error_cnt++;
    if (pready !== 1'b1) close_out();
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // Selector 0 watches irq_o, 1 watches low_power_o
  task automatic wait_lvl(input int sel, input logic v, input int lim);
    repeat (lim) begin
      @(posedge clk_sys_i);
      if ((sel == 0 ? irq_o : low_power_o) === v) return;
    end
    error_cnt++;
    close_out();
  endtask
  initial begin
    logic [7:0] ra [6];
    logic [31:0] rv [6];
    ra = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h3C, 8'h04};
    rv = '{32'h10, 32'h0, 32'h40, 32'h10, 32'h0, 32'h5A8};
    {rst_i, shutdown_pin_i, addr_sel_i, psel, penable, pwrite} = 6'h30;
    {paddr, pwdata, code, lag, lf} = {8'h00, 32'h0, 10'h000, 4'h0, 16'h005F};
    {error_cnt, total_checks} = 0;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Shutdown synchroniser holds the block for two edges after reset
    repeat (3) @(posedge clk_sys_i);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 0);
      chk(rd, rv[i]);
    end
    addr_sel_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    apb(1'b0, cap_scan_pkg::STATUS_OFF, 0);
    chk(rd, 32'h5B8);
    chk(32'(slave_addr_o), 32'(cap_scan_pkg::ADDR_HI));
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, cap_scan_pkg::CTRL_OFF, 2);
      apb(1'b0, cap_scan_pkg::SCALE_OFF, 0);
      chk(rd, 32'h10);
      lf = lfsr(lfsr(lf));
      code <= (r == 0) ? 10'h3FF : lf[9:0];
      lag <= lf[13:10];
      apb(1'b1, cap_scan_pkg::SCALE_OFF, 32'(lf[4:0]));
      apb(1'b1, cap_scan_pkg::OFFSET_OFF, 32'(lf[15:8]));
      apb(1'b1, cap_scan_pkg::IRQ_MASK_OFF, 2);
      apb(1'b1, cap_scan_pkg::CTRL_OFF, 1);
      wait_lvl(0, 1'b1, 5000);
      apb(1'b1, cap_scan_pkg::CTRL_OFF, 0);
      for (int c = 0; c < 16; c++) begin
        exp_q.push_back(corr(int'(code), int'(lf[4:0]), int'(lf[15:8])));
        apb(1'b0, cap_scan_pkg::DATA_OFF + 8'(4 * c), 0);
        chk(rd, 32'(exp_q.pop_front()));
      end
    end
    apb(1'b1, cap_scan_pkg::IRQ_MASK_OFF, 0);
    chk(32'(irq_o), 0);
    apb(1'b1, cap_scan_pkg::IRQ_STAT_OFF, 2);
    apb(1'b1, cap_scan_pkg::IRQ_MASK_OFF, 2);
    chk(32'(irq_o), 0);
    apb(1'b1, cap_scan_pkg::CTRL_OFF, 2);
    code <= 10'h000;
    apb(1'b1, cap_scan_pkg::IDLE_OFF, 2);
    apb(1'b1, cap_scan_pkg::IRQ_MASK_OFF, 1);
    apb(1'b1, cap_scan_pkg::CTRL_OFF, 1);
    wait_lvl(1, 1'b0, 50);
    wait_lvl(1, 1'b1, 20000);
    code <= 10'h3FF;
    wait_lvl(0, 1'b1, 20000);
    wait_lvl(1, 1'b0, 2000);
    apb(1'b0, cap_scan_pkg::IRQ_STAT_OFF, 0);
    chk(rd & 32'h1, 32'h1);
    shutdown_pin_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    apb(1'b1, cap_scan_pkg::SCALE_OFF, 32'h22);
    chk(32'({low_power_o, irq_o}), 32'h2);
    shutdown_pin_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    apb(1'b0, cap_scan_pkg::SCALE_OFF, 0);
    chk(rd, 32'h10);
    close_out();
  end
endmodule // tb
